/* File: dv/aiodr_assertions.sv */
// aiodr_assertions: port-level checks of the record builder.
// assumes bind onto aiodr_top; master holds address until ack.
module aiodr_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        diag_irq_o,
    input wire logic        diag_going_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // shadow of release enable, taken at the write's ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) en_q <= 1'b0;
        else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00) en_q <= wb_dat_i[0];
    end
    // read answer at one address; data is valid while ack high
    sequence s_rd(logic [7:0] a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence
    sequence s_rg(logic [7:0] lo, logic [7:0] hi);
        wb_ack_o && !wb_we_i && wb_adr_i >= lo && wb_adr_i <= hi;
    endsequence
    property p_out0; s_rd(8'h80) |-> wb_dat_o == 32'h0; endproperty
    a_out0: assert property (p_out0) else $error("out byte0 bad");
    property p_out1; s_rd(8'h84) |-> wb_dat_o == 32'h15; endproperty
    a_out1: assert property (p_out1) else $error("out byte1 bad");
    property p_out2; s_rg(8'h88, 8'h8c) |-> wb_dat_o == 32'h0; endproperty
    a_out2: assert property (p_out2) else $error("out byte2/3 bad");
    property p_type; s_rd(8'h50) |-> wb_dat_o == 32'h74; endproperty
    a_type: assert property (p_type) else $error("type byte bad");
    property p_bits; s_rd(8'h54) |-> wb_dat_o == 32'h08; endproperty
    a_bits: assert property (p_bits) else $error("bits byte bad");
    property p_nch; s_rd(8'h58) |-> wb_dat_o == 32'h07; endproperty
    a_nch: assert property (p_nch) else $error("count byte bad");
    property p_sum; s_rd(8'h5c) |-> wb_dat_o[31:7] == 25'h0; endproperty
    a_sum: assert property (p_sum) else $error("summary bit7 set");
    property p_ain; s_rg(8'h60, 8'h70) |-> (wb_dat_o & 32'hffffff2e) == 0; endproperty
    a_ain: assert property (p_ain) else $error("analog byte fixed bits");
    property p_dout; s_rg(8'h74, 8'h78) |-> (wb_dat_o & 32'hffffffe6) == 0; endproperty
    a_dout: assert property (p_dout) else $error("output byte fixed bits");
    property p_hdr; s_rd(8'h40) |-> wb_dat_o[1] == 1'b0; endproperty
    a_hdr: assert property (p_hdr) else $error("header bit1 set");
    property p_irq; $rose(diag_irq_o) |-> en_q || $past(en_q); endproperty
    a_irq: assert property (p_irq) else $error("irq while disabled");
    property p_going; $rose(diag_going_o) |-> en_q || $past(en_q); endproperty
    a_going: assert property (p_going) else $error("going while disabled");
endmodule : aiodr_assertions

bind aiodr_top aiodr_assertions u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .diag_irq_o(diag_irq_o), .diag_going_o(diag_going_o)
);

/* File: dv/aiodr_fault_src.sv */
// aiodr_fault_src: field-side fault source, one scene at a time.
// assumes the bench changes scene_i just after a clock edge.
module aiodr_fault_src (
    input  wire logic [2:0]                scene_i,
    output aiodr_pkg::aiodr_ch_err_t [6:0] ch_err_o,
    output aiodr_pkg::aiodr_mod_err_t      mod_err_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // faults are levels; combinational so inputs are known at time zero
    always_comb begin
        ch_err_o  = '0;
        mod_err_o = '0;
        case (scene_i)
            3'h1: ch_err_o[0] = 5'h1e;
            3'h2: ch_err_o[4] = 5'h04;
            3'h3: ch_err_o[5] = 5'h1f; // under/over must not leak here
            3'h4: ch_err_o[6] = 5'h01;
            3'h5: mod_err_o = 4'hf;
            3'h6: ch_err_o[2] = 5'h08;
            3'h7: ch_err_o[2:0] = {5'h08, 5'h00, 5'h02};
            default: ch_err_o = '0;
        endcase
    end
endmodule : aiodr_fault_src

/* File: dv/analog_io_diag_records_test.sv */
// analog_io_diag_records_test: bus-level test of the record builder.
// assumes aiodr_top with the fault source on its error inputs.
module analog_io_diag_records_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                           clk_i = 1'b0;
    logic                           rst_i = 1'b1;
    logic                           cyc   = 1'b0;
    logic                           we    = 1'b0;
    logic [7:0]                     adr   = 8'h00;
    logic [31:0]                    wdat  = 32'h0;
    logic [2:0]                     scene = 3'h0;
    logic [31:0]                    wb_dat_o;
    logic                           wb_ack_o;
    logic                           diag_irq_o;
    logic                           diag_going_o;
    aiodr_pkg::aiodr_ch_err_t [6:0] ch_err;
    aiodr_pkg::aiodr_mod_err_t      mod_err;
    int                             bad_count   = 0;
    int                             checks_done = 0;
    int                             k;
    logic [31:0]                    rd;
    // scene, record byte, its value, summary byte
    int tbl [5][4] = '{'{1, 8, 8'hd1, 8'h01}, '{2, 12, 8'h40, 8'h10},
        '{3, 13, 8'h19, 8'h20}, '{4, 14, 8'h08, 8'h40}, '{6, 10, 8'h10, 8'h04}};
    logic [7:0] hdr [7] = '{8'h95, 8'h15, 8'h00, 8'h00, 8'h74, 8'h08, 8'h07};
    logic [7:0] outr [4] = '{8'h00, 8'h15, 8'h00, 8'h00};

    aiodr_fault_src u_src (.scene_i(scene), .ch_err_o(ch_err), .mod_err_o(mod_err));
    aiodr_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ch_err_i(ch_err), .mod_err_i(mod_err),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .diag_irq_o(diag_irq_o), .diag_going_o(diag_going_o)
    );
    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // one classic cycle; request held until the rising edge that samples ack high,
    // data taken and request dropped at that same edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        cyc <= 1'b0;
    endtask : xfer
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one record byte lives in the low bits of its own word
    task automatic rec(input int n, input logic [7:0] exp);
        xfer(1'b0, 8'h40 + 8'(n * 4), 32'h0);
        check(rd, {24'h0, exp});
    endtask : rec
    // flags looked at off the edge so updates have landed; return on a rising
    // edge so the next stimulus stays edge aligned
    task automatic flags(input logic [1:0] exp);
        @(negedge clk_i);
        check({30'h0, diag_irq_o, diag_going_o}, {30'h0, exp});
        @(posedge clk_i);
    endtask : flags
    task automatic final_report();
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    // main sequence: layouts with release off, then one in/out event pair
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            scene <= 3'(tbl[i][0]);
            repeat (4) @(posedge clk_i);
            rec(tbl[i][1], 8'(tbl[i][2]));
            rec(7, 8'(tbl[i][3]));
            xfer(1'b0, 8'h40, 32'h0);
            check(rd & 32'h0a, 32'h08);
        end
        scene <= 3'h5;
        repeat (4) @(posedge clk_i);
        for (int n = 0; n < 7; n++) rec(n, hdr[n]);
        rec(15, 8'h00);
        flags(2'b00);
        scene <= 3'h0;
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b0, 8'h00, 32'h0);
        check(rd, 32'h1);
        repeat (6) @(posedge clk_i);
        flags(2'b00);
        scene <= 3'h6;
        for (k = 0; k < 20 && diag_irq_o !== 1'b1; k++) @(negedge clk_i);
        flags(2'b10);
        xfer(1'b0, 8'h04, 32'h0);
        check(rd, 32'h5);
        scene <= 3'h7;
        repeat (4) @(posedge clk_i);
        rec(8, 8'h00);
        scene <= 3'h0;
        repeat (4) @(posedge clk_i);
        rec(10, 8'h10);
        rec(7, 8'h04);
        xfer(1'b1, 8'h08, 32'h1);
        for (k = 0; k < 20 && diag_going_o !== 1'b1; k++) @(negedge clk_i);
        flags(2'b01);
        xfer(1'b0, 8'h04, 32'h0);
        check(rd, 32'hb);
        for (int n = 0; n < 4; n++) begin
            xfer(1'b0, 8'h80 + 8'(n * 4), 32'h0);
            check(rd, {24'h0, outr[n]});
        end
        xfer(1'b1, 8'h08, 32'h1);
        repeat (4) @(posedge clk_i);
        flags(2'b00);
        rec(10, 8'h00);
        final_report();
    end
    // watchdog for a hung handshake
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        final_report();
    end
endmodule : analog_io_diag_records_test

/* File: rtl/aiodr_mem.sv */
// aiodr_mem: snapshot store of the fifteen record bytes with registered read port.
// assumes the writer loads all bytes at once and the reader indexes bytes singly.
module aiodr_mem (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [119:0] data_i,
    input  wire logic [3:0]   raddr_i,
    output logic      [7:0]   rdata_o
);
    logic [7:0] mem_reg [aiodr_pkg::REC_BYTES];

    // whole record captured in one cycle so the reader never sees a mix
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < aiodr_pkg::REC_BYTES; i++) begin
                mem_reg[i] <= 8'h00;
            end
        end else if (load_i) begin
            for (int i = 0; i < aiodr_pkg::REC_BYTES; i++) begin
                mem_reg[i] <= data_i[i*8 +: 8];
            end
        end
    end

    // out of range index reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (int'(raddr_i) < aiodr_pkg::REC_BYTES) begin
            rdata_o <= mem_reg[raddr_i];
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule : aiodr_mem

/* File: rtl/aiodr_pkg.sv */
// aiodr_pkg: constants and carriers for the analog i/o diagnostic record builder.
// assumes one 200 MHz clock, synchronous active-high reset, wishbone classic slave.
// Function
// - outgoing module record is four bytes; bytes zero, two, three are zero.
// - module record byte one bits three..zero hold analog class code 0101b.
// - byte one bit four flags channel info available; bits seven..five reserved zero.
// - channel-specific incoming record spans bytes zero to fourteen, fifteen bytes.
// - first four channel record bytes repeat the incoming module record.
// - byte four holds channel type 74h in bits six..zero, bit seven zero.
// - byte five reports eight diagnostic bits per channel.
// - byte six reports seven channels in the module.
// - summary byte has one error flag per channel zero..six; bit seven zero.
// - analog channels 0..4: param bit0, wire break bit4, under bit6, over bit7.
// - bytes 13,14 for channels 5,6: param bit0, short bit3, wire break bit4.
// - diagnostic interrupt raised only when interrupt release enabled by configuration.
// - after errors clear, outgoing diagnostic signalled if release still enabled.
// - incoming byte zero: failure bit0, bit1 zero, ext bit2, chan bit3, aux bit4, param bit7.
package aiodr_pkg;
    localparam int          NUM_CH        = 7;
    localparam int          NUM_AIN       = 5;
    localparam int          REC_BYTES     = 15;
    localparam int          MOD_BYTES     = 4;
    localparam logic [3:0]  CLASS_ANALOG  = 4'h5;
    localparam logic [7:0]  CHAN_TYPE     = 8'h74;
    localparam logic [7:0]  DIAG_BITS     = 8'h08;
    localparam logic [7:0]  CHAN_COUNT    = 8'h07;
    // bit and byte positions inside the records
    localparam int          BIT_CH_INFO   = 4;
    localparam int          BIT_MOD_FAIL  = 0;
    localparam int          BIT_EXT_ERR   = 2;
    localparam int          BIT_CHAN_ERR  = 3;
    localparam int          BIT_AUX_MISS  = 4;
    localparam int          BIT_PARAM_ERR = 7;
    localparam int          BYTE_SUMMARY  = 7;
    localparam int          BYTE_CH0      = 8;
    // register word offsets (byte addresses)
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_ACK      = 8'h08;
    localparam logic [7:0]  ADDR_REC      = 8'h40;
    localparam logic [7:0]  ADDR_OUT      = 8'h80;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    // status word bit positions
    localparam int          ST_PEND       = 0;
    localparam int          ST_KIND       = 1;
    localparam int          ST_EVENTS     = 2;

    // per-channel raw error inputs
    typedef struct packed {
        logic param_err;
        logic wire_brk;
        logic under;
        logic over;
        logic short_ckt;
    } aiodr_ch_err_t;

    // module-level error inputs
    typedef struct packed {
        logic mod_fail;
        logic ext_err;
        logic aux_miss;
        logic param_err;
    } aiodr_mod_err_t;
endpackage : aiodr_pkg

/* File: rtl/aiodr_top.sv */
// aiodr_top: builds module and channel diagnostic records, raises diagnostic events.
// assumes error inputs synchronous to clk_i; software reads records over wishbone classic.
module aiodr_top (
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_i,
    input  wire aiodr_pkg::aiodr_ch_err_t [6:0]        ch_err_i,
    input  wire aiodr_pkg::aiodr_mod_err_t             mod_err_i,
    input  wire logic                                  wb_cyc_i,
    input  wire logic                                  wb_stb_i,
    input  wire logic                                  wb_we_i,
    input  wire logic [7:0]                            wb_adr_i,
    input  wire logic [3:0]                            wb_sel_i,
    input  wire logic [31:0]                           wb_dat_i,
    output logic      [31:0]                           wb_dat_o,
    output logic                                       wb_ack_o,
    output logic                                       diag_irq_o,
    output logic                                       diag_going_o
);
    typedef enum logic [1:0] {
        AIODR_IDLE,
        AIODR_READ,
        AIODR_DONE
    } aiodr_bus_t;

    // analog channel error byte layout
    function automatic logic [7:0] ain_byte(input aiodr_pkg::aiodr_ch_err_t e);
        ain_byte = {e.over, e.under, 1'b0, e.wire_brk, 3'b000, e.param_err};
    endfunction : ain_byte

    // output channel error byte layout
    function automatic logic [7:0] out_byte(input aiodr_pkg::aiodr_ch_err_t e);
        out_byte = {3'b000, e.wire_brk, e.short_ckt, 2'b00, e.param_err};
    endfunction : out_byte

    logic [7:0]   ch_byte    [aiodr_pkg::NUM_CH];
    logic [6:0]   summary;
    logic [7:0]   mod_byte0;
    logic [7:0]   mod_byte1;
    logic [119:0] rec_live;
    logic         any_err;
    logic         en_reg;
    logic         pend_reg;
    logic         kind_reg;
    logic [15:0]  events_reg;
    logic         err_seen_reg;
    logic         load_snap;
    logic         ack_wr;
    logic [3:0]   mem_idx;
    logic [7:0]   mem_rdata;
    aiodr_bus_t   bus_reg;
    aiodr_bus_t   bus_next;

    // per-channel bytes and summary flags
    always_comb begin
        for (int c = 0; c < aiodr_pkg::NUM_CH; c++) begin
            if (c < aiodr_pkg::NUM_AIN) begin
                ch_byte[c] = ain_byte(ch_err_i[c]);
            end else begin
                ch_byte[c] = out_byte(ch_err_i[c]);
            end
            summary[c] = |ch_byte[c];
        end
    end

    // module record bytes
    always_comb begin
        mod_byte0 = 8'h00;
        mod_byte0[aiodr_pkg::BIT_MOD_FAIL]  = mod_err_i.mod_fail;
        mod_byte0[aiodr_pkg::BIT_EXT_ERR]   = mod_err_i.ext_err;
        mod_byte0[aiodr_pkg::BIT_CHAN_ERR]  = |summary;
        mod_byte0[aiodr_pkg::BIT_AUX_MISS]  = mod_err_i.aux_miss;
        mod_byte0[aiodr_pkg::BIT_PARAM_ERR] = mod_err_i.param_err;
        mod_byte1 = {3'b000, 1'b1, aiodr_pkg::CLASS_ANALOG};
    end

    // fifteen byte channel record, byte zero lowest
    always_comb begin
        rec_live = '0;
        rec_live[0  +: 8] = mod_byte0;
        rec_live[8  +: 8] = mod_byte1;
        rec_live[32 +: 8] = {1'b0, aiodr_pkg::CHAN_TYPE[6:0]};
        rec_live[40 +: 8] = aiodr_pkg::DIAG_BITS;
        rec_live[48 +: 8] = aiodr_pkg::CHAN_COUNT;
        rec_live[56 +: 8] = {1'b0, summary};
        for (int c = 0; c < aiodr_pkg::NUM_CH; c++) begin
            rec_live[(aiodr_pkg::BYTE_CH0 + c)*8 +: 8] = ch_byte[c];
        end
    end

    assign any_err = |mod_byte0;

    // snapshot only when no event is pending, keeping the record consistent
    assign load_snap = !pend_reg;

    aiodr_mem u_mem (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (load_snap),
        .data_i  (rec_live),
        .raddr_i (mem_idx),
        .rdata_o (mem_rdata)
    );

    // control register: bit 0 enables diagnostic interrupt release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= aiodr_pkg::CTRL_RESET[0];
        end else if (ack_wr && wb_adr_i == aiodr_pkg::ADDR_CTRL && wb_sel_i[0]) begin
            en_reg <= wb_dat_i[0];
        end
    end

    // incoming on first error, outgoing when errors clear; freeze while pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg     <= 1'b0;
            kind_reg     <= 1'b0;
            err_seen_reg <= 1'b0;
            events_reg   <= 16'h0000;
        end else if (!pend_reg) begin
            if (en_reg && any_err && !err_seen_reg) begin
                pend_reg     <= 1'b1;
                kind_reg     <= 1'b0;
                err_seen_reg <= 1'b1;
                events_reg   <= events_reg + 16'h0001;
            end else if (en_reg && !any_err && err_seen_reg) begin
                pend_reg     <= 1'b1;
                kind_reg     <= 1'b1;
                err_seen_reg <= 1'b0;
                events_reg   <= events_reg + 16'h0001;
            end else if (!en_reg) begin
                err_seen_reg <= 1'b0;
            end
        end else if (ack_wr && wb_adr_i == aiodr_pkg::ADDR_ACK && wb_sel_i[0]
                     && wb_dat_i[0]) begin
            pend_reg <= 1'b0;
        end
    end

    // interrupt outputs follow pending state and its kind
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diag_irq_o   <= 1'b0;
            diag_going_o <= 1'b0;
        end else begin
            diag_irq_o   <= pend_reg && !kind_reg;
            diag_going_o <= pend_reg && kind_reg;
        end
    end

    // record byte index from word address
    assign mem_idx = wb_adr_i[5:2];

    // bus sequencer: two cycles for reads so memory data is registered
    always_comb begin
        bus_next = bus_reg;
        case (bus_reg)
            AIODR_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    bus_next = wb_we_i ? AIODR_DONE : AIODR_READ;
                end
            end
            AIODR_READ: begin
                bus_next = AIODR_DONE;
            end
            AIODR_DONE: begin
                bus_next = AIODR_IDLE;
            end
            default: begin
                bus_next = AIODR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_reg <= AIODR_IDLE;
        end else begin
            bus_reg <= bus_next;
        end
    end

    // write takes effect in the ack cycle
    assign ack_wr = (bus_reg == AIODR_DONE) && wb_we_i && wb_cyc_i && wb_stb_i;

    // ack and read data; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= (bus_next == AIODR_DONE) && wb_cyc_i && wb_stb_i;
            if (bus_reg == AIODR_IDLE && wb_cyc_i && wb_stb_i && wb_we_i) begin
                wb_dat_o <= 32'h0000_0000;
            end else if (bus_reg == AIODR_READ) begin
                if (wb_adr_i == aiodr_pkg::ADDR_CTRL) begin
                    wb_dat_o <= {31'h0000_0000, en_reg};
                end else if (wb_adr_i == aiodr_pkg::ADDR_STATUS) begin
                    wb_dat_o <= {14'h0000, events_reg, kind_reg, pend_reg};
                end else if (wb_adr_i >= aiodr_pkg::ADDR_REC
                             && wb_adr_i < aiodr_pkg::ADDR_REC + 8'h3c) begin
                    wb_dat_o <= {24'h00_0000, mem_rdata};
                end else if (wb_adr_i == aiodr_pkg::ADDR_OUT + 8'h04) begin
                    wb_dat_o <= {24'h00_0000, mod_byte1};
                end else if (wb_adr_i >= aiodr_pkg::ADDR_OUT
                             && wb_adr_i < aiodr_pkg::ADDR_OUT + 8'h10) begin
                    wb_dat_o <= 32'h0000_0000;
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end
endmodule : aiodr_top
